// ---- rtl/cpla_attach.v ----
// Purpose: poll decision/capture latches and initial-load latches of one
//          channel device adapter, with an APB register port
// Assumes: inputs synchronous to I_CORE_CLK; tags sampled every cycle
// Notes:   outgoing tags come straight from flip-flops
`timescale 1ns/10ps
`include "cpla_map.vh"

module cpla_attach (
	// clock and reset
	input  wire        I_CORE_CLK,
	input  wire        I_SYS_RST,
	// apb slave
	input  wire        I_PSEL,
	input  wire        I_PENABLE,
	input  wire        I_PWRITE,
	input  wire [11:0] I_PADDR,
	input  wire [31:0] I_PWDATA,
	output reg  [31:0] O_PRDATA,
	output reg         O_PREADY,
	output reg         O_PSLVERR,
	// poll group from channel
	input  wire        I_POLL,
	input  wire [4:0]  I_POLL_ID,
	input  wire        I_POLL_PRIME,
	// service group from channel
	input  wire        I_ADDR_GATE,
	input  wire        I_SVC_GATE,
	input  wire        I_DATA_STROBE,
	input  wire        I_ADDR_BIT16,
	input  wire [7:0]  I_ADDR_DEV,
	input  wire [7:0]  I_DATA_CMD,
	input  wire [1:0]  I_STATUS_SEL,
	// channel directed resets
	input  wire        I_SYSTEM_RESET,
	input  wire        I_POWER_ON_RESET,
	input  wire        I_HALT_RESET,
	input  wire        I_INIT_LOAD,
	// jumpers
	input  wire [1:0]  I_LOAD_SRC_JMP,
	// tags to channel
	output reg         O_POLL_PROPAGATE,
	output reg         O_POLL_RETURN,
	output reg         O_SVC_GATE_RETURN,
	output reg         O_CS_REQ_IN,
	output reg  [15:0] O_REQ_IN,
	output reg         O_LOAD_TAG,
	output reg         O_LOAD_ENABLE
);

	// level decode to one request-in line
	function [15:0] lvl_dec;
		input [3:0] lvl;
		begin
			lvl_dec = 16'h0001 << lvl;
		end
	endfunction

	// poll tracking: idle, poll held, one settle cycle
	localparam [2:0] S_IDLE = 3'b001;
	localparam [2:0] S_HELD = 3'b010;
	localparam [2:0] S_DONE = 3'b100;

	reg  [2:0]  poll_st_q;
	reg         cs_pend_q;
	reg         int_pend_q;
	reg         cs_samp_q;
	reg         int_samp_q;
	reg         decide_q;
	reg         capt_q;
	reg         capt_is_cs_q;
	reg         svc_capt_q;
	reg         svc_busy_q;
	reg         dummy_q;
	reg  [3:0]  level_q;
	reg  [7:0]  devaddr_q;
	reg  [1:0]  src_q;
	reg         svc_done_q;
	reg         sysrst_q;
	reg         ag_q;
	reg         load_tag_q;
	reg         load_en_q;
	reg         int_req_d;
	// arm marks a tag clear taken with initiate-load
	reg         load_arm_q;
	wire [1:0]  src_eff;
	wire [31:0] status_w;

	// channel side and apb decodes
	wire chan_rst  = I_SYSTEM_RESET | I_POWER_ON_RESET | I_HALT_RESET;
	wire sel_me    = I_ADDR_BIT16 & (I_ADDR_DEV == devaddr_q);
	wire cmd_dreset = sel_me & I_ADDR_GATE & (I_DATA_CMD == `CPLA_CMD_DEV_RESET);
	wire cmd_prep  = sel_me & I_ADDR_GATE & ~ag_q & (I_DATA_CMD == `CPLA_CMD_PREPARE);
	wire pid_cs    = I_POLL_ID[`CPLA_PID_CS_BIT];
	wire lvl_hit   = (I_POLL_ID[4:1] == level_q);
	wire poll_rise = I_POLL & (poll_st_q == S_IDLE);
	// jumper sets the load source; a nonzero control field overrides it
	assign src_eff = (src_q != `CPLA_SRC_NONE) ? src_q : I_LOAD_SRC_JMP;
	wire load_sel  = (src_eff != `CPLA_SRC_NONE) & (I_STATUS_SEL == src_eff);
	wire sr_fall   = sysrst_q & ~I_SYSTEM_RESET;
	wire apb_wr    = I_PSEL & I_PENABLE & I_PWRITE & ~O_PREADY;
	wire apb_rd    = I_PSEL & I_PENABLE & ~I_PWRITE & ~O_PREADY;
	wire hit_ctrl  = (I_PADDR == `CPLA_OFS_CTRL);
	wire hit_level = (I_PADDR == `CPLA_OFS_LEVEL);
	wire hit_dev   = (I_PADDR == `CPLA_OFS_DEVADDR);
	wire hit_any   = hit_ctrl | hit_level | hit_dev | (I_PADDR == `CPLA_OFS_STATUS);

	// status word, one field per bit
	assign status_w[31:9]              = 23'h000000;
	assign status_w[`CPLA_ST_CS_PEND]  = cs_pend_q;
	assign status_w[`CPLA_ST_INT_PEND] = int_pend_q;
	assign status_w[`CPLA_ST_CAPT]     = capt_q;
	assign status_w[`CPLA_ST_SVC_CAPT] = svc_capt_q;
	assign status_w[`CPLA_ST_LOAD_TAG] = load_tag_q;
	assign status_w[`CPLA_ST_LOAD_EN]  = load_en_q;
	assign status_w[`CPLA_ST_DECIDE]   = decide_q;
	assign status_w[`CPLA_ST_SEL]      = load_sel;
	assign status_w[`CPLA_ST_DUMMY]    = dummy_q;

	// software request of interrupt is refused while a steal request pends
	wire sw_int  = apb_wr & hit_ctrl & I_PWDATA[`CPLA_CTRL_INT_REQ];
	wire sw_cs   = apb_wr & hit_ctrl & I_PWDATA[`CPLA_CTRL_CS_REQ];

	// interrupt source latch
	always @* begin
		int_req_d = int_pend_q;
		if (sw_int & ~cs_pend_q & ~sw_cs)
			int_req_d = 1'b1;
		if (cmd_dreset | cmd_prep)
			int_req_d = 1'b0;
		// capture latch is gone by service end; the kind flag survives
		if (svc_done_q & ~capt_is_cs_q)
			int_req_d = 1'b0;
	end

	// registers, request sources and service bookkeeping
	always @(posedge I_CORE_CLK) begin
		if (I_SYS_RST) begin
			level_q    <= `CPLA_LEVEL_RST;
			devaddr_q  <= `CPLA_DEVADDR_RST;
			src_q      <= `CPLA_SRC_NONE;
			cs_pend_q  <= 1'b0;
			int_pend_q <= 1'b0;
			svc_done_q <= 1'b0;
			dummy_q    <= 1'b0;
			ag_q       <= 1'b0;
		end else begin
			ag_q <= I_ADDR_GATE;
			svc_done_q <= svc_busy_q & ~I_SVC_GATE & ~I_DATA_STROBE;
			if (apb_wr & hit_level)
				level_q <= I_PWDATA[3:0];
			if (apb_wr & hit_dev)
				devaddr_q <= I_PWDATA[7:0];
			if (apb_wr & hit_ctrl)
				src_q <= I_PWDATA[`CPLA_CTRL_SRC_HI:`CPLA_CTRL_SRC_LO];
			if (chan_rst) begin
				cs_pend_q  <= 1'b0;
				int_pend_q <= 1'b0;
				dummy_q    <= 1'b0;
			end else begin
				// device reset leaves a presented steal request standing
				if (cmd_dreset & cs_pend_q)
					dummy_q <= 1'b1;
				if (sw_cs & ~int_pend_q)
					cs_pend_q <= 1'b1;
				else if (svc_done_q & capt_is_cs_q) begin
					cs_pend_q <= 1'b0;
					dummy_q   <= 1'b0;
				end
				int_pend_q <= int_req_d;
			end
		end
	end

	// sample latches, decision, capture
	always @(posedge I_CORE_CLK) begin
		if (I_SYS_RST | chan_rst) begin
			poll_st_q    <= S_IDLE;
			cs_samp_q    <= 1'b0;
			int_samp_q   <= 1'b0;
			decide_q     <= 1'b0;
			capt_q       <= 1'b0;
			capt_is_cs_q <= 1'b0;
		end else begin
			if (~I_POLL) begin
				// raised poll freezes the sample; idle poll reopens it
				cs_samp_q  <= pid_cs ? cs_pend_q & ~capt_q : 1'b0;
				int_samp_q <= ~pid_cs ? int_pend_q & lvl_hit & ~capt_q : 1'b0;
				decide_q   <= cs_samp_q | int_samp_q;
			end
			case (poll_st_q)
				S_IDLE: begin
					if (I_POLL) begin
						poll_st_q <= S_HELD;
						if (decide_q) begin
							capt_q       <= 1'b1;
							capt_is_cs_q <= cs_samp_q;
						end
					end
				end
				S_HELD: begin
					if (~I_POLL)
						poll_st_q <= S_DONE;
				end
				S_DONE: begin
					poll_st_q <= S_IDLE;
				end
				default: begin
					poll_st_q <= S_IDLE;
				end
			endcase
			if (svc_capt_q)
				capt_q <= 1'b0;
		end
	end

	// service gate capture and sequence tracking
	always @(posedge I_CORE_CLK) begin
		if (I_SYS_RST | chan_rst) begin
			svc_capt_q <= 1'b0;
			svc_busy_q <= 1'b0;
		end else begin
			// set on service gate leading edge after capture, data strobe not used
			if (capt_q & I_SVC_GATE & ~svc_busy_q) begin
				svc_capt_q <= 1'b1;
				svc_busy_q <= 1'b1;
			end else if (svc_busy_q & ~I_SVC_GATE & ~I_DATA_STROBE)
				svc_capt_q <= 1'b0;
			if (svc_done_q)
				svc_busy_q <= 1'b0;
		end
	end

	// initial-load latches
	always @(posedge I_CORE_CLK) begin
		if (I_SYS_RST) begin
			sysrst_q   <= 1'b0;
			load_tag_q <= 1'b0;
			load_en_q  <= 1'b0;
			load_arm_q <= 1'b0;
		end else begin
			sysrst_q <= I_SYSTEM_RESET;
			if (I_SYSTEM_RESET & I_INIT_LOAD & load_sel) begin
				load_tag_q <= 1'b0;
				load_arm_q <= 1'b1;
			end else if (I_SYSTEM_RESET & ~I_INIT_LOAD & load_en_q) begin
				load_tag_q <= 1'b0;
				load_en_q  <= 1'b0;
			end
			if (sr_fall) begin
				// trigger samples the tag before the latch updates
				load_en_q  <= load_tag_q;
				load_arm_q <= 1'b0;
				// only a reset that carried initiate-load raises the tag
				if (load_arm_q)
					load_tag_q <= 1'b1;
			end
		end
	end

	// tag drivers
	always @(posedge I_CORE_CLK) begin
		if (I_SYS_RST) begin
			O_POLL_PROPAGATE  <= 1'b0;
			O_POLL_RETURN     <= 1'b0;
			O_SVC_GATE_RETURN <= 1'b0;
			O_CS_REQ_IN       <= 1'b0;
			O_REQ_IN          <= 16'h0000;
			O_LOAD_TAG        <= 1'b0;
			O_LOAD_ENABLE     <= 1'b0;
		end else begin
			O_POLL_PROPAGATE  <= ~chan_rst & I_POLL & ~capt_q & ~decide_q;
			O_POLL_RETURN     <= ~chan_rst & I_POLL & (decide_q | capt_q);
			O_SVC_GATE_RETURN <= ~chan_rst & svc_busy_q & (I_SVC_GATE | I_DATA_STROBE);
			O_CS_REQ_IN       <= ~chan_rst & cs_pend_q & ~capt_q & ~svc_busy_q;
			O_REQ_IN          <= (~chan_rst & int_pend_q & ~capt_q & ~svc_busy_q) ?
				lvl_dec(level_q) : 16'h0000;
			O_LOAD_TAG        <= load_tag_q;
			O_LOAD_ENABLE     <= load_en_q;
		end
	end

	// apb slave, one wait state on every access
	always @(posedge I_CORE_CLK) begin
		if (I_SYS_RST) begin
			O_PRDATA  <= 32'h00000000;
			O_PREADY  <= 1'b0;
			O_PSLVERR <= 1'b0;
		end else begin
			O_PREADY  <= I_PSEL & I_PENABLE & ~O_PREADY;
			O_PSLVERR <= I_PSEL & I_PENABLE & ~O_PREADY & ~hit_any;
			O_PRDATA  <= 32'h00000000;
			if (apb_rd) begin
				case (I_PADDR)
					`CPLA_OFS_CTRL:    O_PRDATA <= {27'h0000000, src_q, 3'h0};
					`CPLA_OFS_LEVEL:   O_PRDATA <= {28'h0000000, level_q};
					`CPLA_OFS_DEVADDR: O_PRDATA <= {24'h000000, devaddr_q};
					`CPLA_OFS_STATUS:  O_PRDATA <= status_w;
					default:           O_PRDATA <= 32'h00000000;
				endcase
			end
		end
	end

endmodule // cpla_attach

// ---- rtl/cpla_map.vh ----
// Purpose: constants for the channel poll and initial-load attachment
// Assumes: single device, cycle steal and interrupt never posted together
// Notes:   offsets are byte addresses of 32-bit APB words
`ifndef CPLA_MAP_VH
`define CPLA_MAP_VH

`define CPLA_OFS_CTRL     12'h000
`define CPLA_OFS_STATUS   12'h004
`define CPLA_OFS_LEVEL    12'h008
`define CPLA_OFS_DEVADDR  12'h00C

// control register fields
`define CPLA_CTRL_CS_REQ   0
`define CPLA_CTRL_INT_REQ  1
`define CPLA_CTRL_SVC_DONE 2
`define CPLA_CTRL_SRC_LO   3
`define CPLA_CTRL_SRC_HI   4
`define CPLA_CTRL_RST      5'h00

// status register fields
`define CPLA_ST_CS_PEND    0
`define CPLA_ST_INT_PEND   1
`define CPLA_ST_CAPT       2
`define CPLA_ST_SVC_CAPT   3
`define CPLA_ST_LOAD_TAG   4
`define CPLA_ST_LOAD_EN    5
`define CPLA_ST_DECIDE     6
`define CPLA_ST_SEL        7
`define CPLA_ST_DUMMY      8

// initial-load source jumper codes
`define CPLA_SRC_NONE      2'h0
`define CPLA_SRC_PRIMARY   2'h1
`define CPLA_SRC_ALTERNATE 2'h2

// poll identifier bit 0 marks cycle steal when set, interrupt when clear
`define CPLA_PID_CS_BIT    0
`define CPLA_LEVEL_W       4
`define CPLA_LEVEL_RST     4'h0
`define CPLA_DEVADDR_RST   8'h00

// device reset command code on the data bus low byte
`define CPLA_CMD_DEV_RESET 8'h0F
`define CPLA_CMD_PREPARE   8'h60

`endif

// ---- verification/cpla_monitor.sv ----
// Purpose: tag timing checks for cpla_attach
// Assumes: one clock, sync reset
// Notes:   bound below the module
`timescale 1ns/10ps
module cpla_monitor (
	input wire        I_CORE_CLK, I_SYS_RST, I_POLL, I_SVC_GATE, I_DATA_STROBE,
	input wire        I_SYSTEM_RESET, I_POWER_ON_RESET, I_HALT_RESET, I_INIT_LOAD,
	input wire        O_POLL_PROPAGATE, O_POLL_RETURN, O_SVC_GATE_RETURN,
	input wire        O_CS_REQ_IN, O_LOAD_TAG, O_LOAD_ENABLE,
	input wire [15:0] O_REQ_IN
);
	wire chr  = I_SYSTEM_RESET | I_POWER_ON_RESET | I_HALT_RESET;
	wire nreq = !O_CS_REQ_IN && O_REQ_IN == 16'h0000;
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff (I_SYS_RST);
	a_idle_pass: assert property ($rose(I_POLL) && nreq && !chr |=> O_POLL_PROPAGATE)
		else $error("poll not passed");
	a_poll_answer: assert property ($rose(I_POLL) && !chr |=> O_POLL_RETURN != O_POLL_PROPAGATE)
		else $error("no poll answer");
	a_ret_hold: assert property (O_POLL_RETURN && I_POLL && !chr |=> O_POLL_RETURN)
		else $error("return dropped");
	a_req_block: assert property ($rose(O_POLL_RETURN) |-> ##[0:2] nreq)
		else $error("request not blocked");
	a_chan_degate: assert property (chr |=> !O_POLL_RETURN && !O_SVC_GATE_RETURN && nreq)
		else $error("tags not degated");
	a_svc_cause: assert property ($rose(O_SVC_GATE_RETURN) |-> $past(I_SVC_GATE))
		else $error("return without gate");
	a_svc_end: assert property (O_SVC_GATE_RETURN && !I_SVC_GATE && !I_DATA_STROBE
		|-> ##[1:2] !O_SVC_GATE_RETURN) else $error("return stuck");
	a_load_clear: assert property (I_SYSTEM_RESET && I_INIT_LOAD |-> ##2 !O_LOAD_TAG)
		else $error("load tag kept");
	a_load_first: assert property ($fell(I_SYSTEM_RESET) && $past(I_INIT_LOAD)
		|-> ##2 O_LOAD_TAG && !O_LOAD_ENABLE) else $error("first reset end");
	a_load_hold: assert property (I_SYSTEM_RESET && !I_INIT_LOAD && O_LOAD_TAG
		&& !O_LOAD_ENABLE |=> O_LOAD_TAG) else $error("load tag lost");
	a_load_third: assert property (I_SYSTEM_RESET && O_LOAD_ENABLE && !I_INIT_LOAD
		|-> ##2 !O_LOAD_TAG && !O_LOAD_ENABLE) else $error("load not cleared");
endmodule // cpla_monitor
bind cpla_attach cpla_monitor cpla_monitor_i (.*);

// ---- verification/cpla_chan.sv ----
// Purpose: channel model for poll, service and command tags
// Assumes: one device, one sequence at a time
// Notes:   released command lines show the inverse value
`timescale 1ns/10ps
module cpla_chan (
	input  wire       clk, ret, prop, sret,
	output reg        poll = 0, sg = 0, ds = 0, ag = 0, b16 = 0,
	output reg  [4:0] pid = 0,
	output reg  [7:0] dev = 0, cmd = 0
);
	// identifier settles before poll; never polls during a command
	task automatic do_poll(input logic [4:0] id, output logic cap);
		int n = 0;
		pid <= id;
		repeat (3) @(posedge clk);
		poll <= 1'b1;
		do @(posedge clk); while (ret !== 1'b1 && prop !== 1'b1 && ++n < 9);
		cap = ret;
		poll <= 1'b0;
		@(posedge clk);
	endtask
	task automatic do_svc(output logic ok);
		int n = 0;
		sg <= 1'b1;
		ds <= 1'b1;
		do @(posedge clk); while (sret !== 1'b1 && ++n < 9);
		ok = sret;
		sg <= 1'b0;
		ds <= 1'b0;
		do @(posedge clk); while (sret !== 1'b0 && ++n < 20);
	endtask
	task automatic do_cmd(input logic [7:0] a, c);
		b16 <= 1'b1;
		dev <= a;
		cmd <= c;
		ag <= 1'b1;
		ds <= 1'b1;
		repeat (3) @(posedge clk);
		{ag, ds, b16} <= 3'h0;
		dev <= ~a;
		cmd <= ~c;
		@(posedge clk);
	endtask
endmodule // cpla_chan

// ---- verification/tb.sv ----
// Purpose: self-checking bench for cpla_attach
// Assumes: channel model drives poll side
// Notes:   seed 90 for levels and addresses
`timescale 1ns/10ps
`include "cpla_map.vh"
`define CHK(g, x) begin \
	cmp_count++; \
	if ((g) !== (x)) begin \
		mismatches++; \
		$display("wrong value at %0t: %h vs %h", $time, g, x); \
	end \
end
module tb;
	logic        I_CORE_CLK = 0, I_SYS_RST = 1, I_PSEL = 0, I_PENABLE = 0, I_PWRITE = 0;
	logic        I_SYSTEM_RESET = 0, I_POWER_ON_RESET = 0, I_HALT_RESET = 0;
	logic        I_INIT_LOAD = 0, I_POLL_PRIME = 0, e, c, mid;
	logic [11:0] I_PADDR = 0;
	logic [31:0] I_PWDATA = 0, r;
	logic [1:0]  I_STATUS_SEL = 0, I_LOAD_SRC_JMP = 0;
	logic [7:0]  dv;
	logic [3:0]  l, m;
	wire         O_PREADY, O_PSLVERR, O_POLL_PROPAGATE, O_POLL_RETURN, O_SVC_GATE_RETURN;
	wire         O_CS_REQ_IN, O_LOAD_TAG, O_LOAD_ENABLE, I_POLL, I_SVC_GATE;
	wire         I_DATA_STROBE, I_ADDR_GATE, I_ADDR_BIT16;
	wire  [31:0] O_PRDATA;
	wire  [15:0] O_REQ_IN;
	wire  [4:0]  I_POLL_ID;
	wire  [7:0]  I_ADDR_DEV, I_DATA_CMD;
	int          mismatches = 0, cmp_count = 0, cyc = 0, i;
	always #5 I_CORE_CLK = ~I_CORE_CLK;
	cpla_attach cpla_attach_i (.*);
	cpla_chan cpla_chan_i (.clk(I_CORE_CLK), .ret(O_POLL_RETURN), .prop(O_POLL_PROPAGATE),
		.sret(O_SVC_GATE_RETURN), .poll(I_POLL), .sg(I_SVC_GATE), .ds(I_DATA_STROBE),
		.ag(I_ADDR_GATE), .b16(I_ADDR_BIT16), .pid(I_POLL_ID), .dev(I_ADDR_DEV),
		.cmd(I_DATA_CMD));
	function automatic logic [15:0] f_req(input logic [3:0] v);
		f_req = 16'h0001 << v;
	endfunction
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		I_PSEL <= 1'b1;
		I_PWRITE <= w;
		I_PADDR <= a;
		I_PWDATA <= d;
		@(posedge I_CORE_CLK);
		I_PENABLE <= 1'b1;
		do @(posedge I_CORE_CLK); while (O_PREADY !== 1'b1 && ++n < 20);
		r = O_PRDATA;
		e = O_PSLVERR;
		`CHK(O_PREADY, 1'b1)
		I_PSEL <= 1'b0;
		I_PENABLE <= 1'b0;
		@(posedge I_CORE_CLK);
	endtask
	task automatic sysrst(input logic ini);
		I_SYSTEM_RESET <= 1'b1;
		I_INIT_LOAD <= ini;
		repeat (3) @(posedge I_CORE_CLK);
		mid = O_LOAD_TAG;
		I_SYSTEM_RESET <= 1'b0;
		@(posedge I_CORE_CLK);
		I_INIT_LOAD <= 1'b0;
		repeat (2) @(posedge I_CORE_CLK);
	endtask
	task final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge I_CORE_CLK) begin
		if (++cyc == 20000) begin
			mismatches++;
			final_report();
		end
	end
	initial begin
		repeat (3) @(posedge I_CORE_CLK);
		I_SYS_RST <= 1'b0;
		@(posedge I_CORE_CLK);
		i = $urandom(90);
		dv = $urandom;
		// reset values, then one unmapped word
		for (i = 0; i < 4; i++) begin
			apb(1'b0, 12'(i ? i * 4 + 4 : 0), 32'h0);
			`CHK(e, 1'(i == 3))
			if (i < 3) `CHK(r, 32'h0)
		end
		apb(1'b1, `CPLA_OFS_DEVADDR, {24'h0, dv});
		apb(1'b0, `CPLA_OFS_DEVADDR, 32'h0);
		`CHK(r, {24'h0, dv})
		for (i = 0; i < 8; i++) begin
			l = $urandom;
			m = i[0] ? l : l + 4'h1;
			apb(1'b1, `CPLA_OFS_LEVEL, {28'h0, l});
			apb(1'b1, `CPLA_OFS_CTRL, 32'h2);
			`CHK(O_REQ_IN, f_req(l))
			cpla_chan_i.do_poll({m, 1'b0}, c);
			`CHK(c, l == m)
			if (c) begin
				`CHK(O_REQ_IN, 16'h0000)
				cpla_chan_i.do_svc(c);
				`CHK(c, 1'b1)
			end else
				cpla_chan_i.do_cmd(dv, `CPLA_CMD_DEV_RESET);
			repeat (2) @(posedge I_CORE_CLK);
			`CHK(O_REQ_IN, 16'h0000)
		end
		apb(1'b1, `CPLA_OFS_CTRL, 32'h1);
		`CHK(O_CS_REQ_IN, 1'b1)
		cpla_chan_i.do_cmd(dv, `CPLA_CMD_DEV_RESET);
		`CHK(O_CS_REQ_IN, 1'b1)
		cpla_chan_i.do_poll(5'h01, c);
		`CHK(c, 1'b1)
		cpla_chan_i.do_svc(c);
		`CHK(c, 1'b1)
		repeat (2) @(posedge I_CORE_CLK);
		`CHK(O_CS_REQ_IN, 1'b0)
		cpla_chan_i.do_poll(5'($urandom), c);
		`CHK(c, 1'b0)
		apb(1'b1, `CPLA_OFS_CTRL, 32'h8);
		I_STATUS_SEL <= `CPLA_SRC_PRIMARY;
		sysrst(1'b1);
		`CHK({mid, O_LOAD_TAG, O_LOAD_ENABLE}, 3'h2)
		apb(1'b0, `CPLA_OFS_STATUS, 32'h0);
		`CHK(r, 32'h00000090)
		sysrst(1'b0);
		`CHK({mid, O_LOAD_TAG, O_LOAD_ENABLE}, 3'h7)
		sysrst(1'b0);
		`CHK({O_LOAD_TAG, O_LOAD_ENABLE}, 2'h0)
		for (i = 0; i < 2; i++) begin
			apb(1'b1, `CPLA_OFS_CTRL, 32'h1);
			I_HALT_RESET <= i[0];
			I_POWER_ON_RESET <= !i[0];
			repeat (2) @(posedge I_CORE_CLK);
			`CHK(O_CS_REQ_IN, 1'b0)
			{I_HALT_RESET, I_POWER_ON_RESET} <= 2'h0;
			@(posedge I_CORE_CLK);
		end
		final_report();
	end
endmodule // tb
